// >>> shared/hwmfac_regs.svh
/*
 Register offsets, field positions, reset values and timing counts for the
 fan automatic-control and monitor block. Assumes a 250 MHz core clock.
*/
`ifndef HWMFAC_REGS_SVH
`define HWMFAC_REGS_SVH
`define HWMFAC_OFS_CONFIG 8'h00
`define HWMFAC_OFS_SBUS_ADDR 8'h48
`define HWMFAC_OFS_ENABLE 8'h50
`define HWMFAC_OFS_FAN_DIV 8'h0b
`define HWMFAC_OFS_TEMP_IN 8'h29
`define HWMFAC_OFS_VOLT_IN 8'h20
`define HWMFAC_OFS_STATUS 8'h51
`define HWMFAC_OFS_TACH4_LSB 8'h80
`define HWMFAC_OFS_TACH4_MSB 8'h81
`define HWMFAC_OFS_TACH5_LSB 8'h82
`define HWMFAC_OFS_TACH5_MSB 8'h83
`define HWMFAC_OFS_LIM4_LSB 8'h84
`define HWMFAC_OFS_LIM4_MSB 8'h85
`define HWMFAC_OFS_LIM5_LSB 8'h86
`define HWMFAC_OFS_LIM5_MSB 8'h87
`define HWMFAC_OFS_F4_START 8'h93
`define HWMFAC_OFS_F4_CTRL 8'h94
`define HWMFAC_OFS_F4_FSOFF 8'h95
`define HWMFAC_OFS_F5_START 8'h9b
`define HWMFAC_OFS_F5_CTRL 8'h9c
`define HWMFAC_OFS_F5_FSOFF 8'h9d
`define HWMFAC_CFG_START 0
`define HWMFAC_CFG_STOP 3
`define HWMFAC_CFG_SWRST 7
`define HWMFAC_CTL_SMOOTH 7
`define HWMFAC_CTL_FEEDBK 5
`define HWMFAC_RST_START 8'h00
`define HWMFAC_RST_CTRL 8'h00
`define HWMFAC_RST_FSOFF 8'h7f
`define HWMFAC_RST_CONFIG 8'h00
`define HWMFAC_RST_SBUS 8'h2d
`define HWMFAC_DUTY_FULL 7'h7f
`define HWMFAC_CLK_HZ 250000000
`define HWMFAC_TACH_HZ 22500
`define HWMFAC_SPIN1_MS 125
`define HWMFAC_SPIN2_MS 325
`define HWMFAC_SPIN3_MS 1000
`define HWMFAC_TACH_DIV (`HWMFAC_CLK_HZ / `HWMFAC_TACH_HZ)
`define HWMFAC_MS_CYC (`HWMFAC_CLK_HZ / 1000)
`endif

// >>> shared/hwmfac_pkg.sv
/*
 Types for the fan automatic-control block. Used by rtl/hwmfac_top.sv.
*/
`default_nettype none
package hwmfac_pkg;
   typedef enum logic [3:0] {
      MON_IDLE = 4'b0001,
      MON_ONCE = 4'b0010,
      MON_LOOP = 4'b0100,
      MON_STOP = 4'b1000
   } hwmfac_mon_type;
endpackage
`default_nettype wire

// >>> rtl/hwmfac_top.sv
/*
 Hardware monitor fan automatic control for fan outputs 4 and 5, with
 monitor reset, loop start, tach counting and sensor code capture.
 Assumes register strobes and sensor inputs are synchronous to core_clk.
 ADC and temperature codes arrive already converted from the analogue front.
*/
// The implementer's own choice: strobed register access.
`include "hwmfac_regs.svh"
`default_nettype none
module hwmfac_top #(
   parameter int TACH_DIV = `HWMFAC_TACH_DIV,
   parameter int MS_CYC = `HWMFAC_MS_CYC,
   parameter int TACH_W = 16
)(
   // Clock and reset.
   input wire logic core_clk,
   input wire logic nrst,
   // Register port.
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Sensing side.
   input wire logic [1:0] fan_speed_input,
   input wire logic [7:0] temp_sense_input,
   input wire logic [7:0] volt_code,
   input wire logic [1:0] fan_auto_mode,
   input wire logic [1:0] fan_onoff_mode,
   // Drive and status.
   output logic [6:0] fan4_drive_output,
   output logic [6:0] fan5_drive_output,
   output logic [1:0] spinup_active,
   output logic monitor_running,
   output logic adc_active
);
   // The spin counters are 32 bits and the prescaler 16 bits wide.
   if (TACH_DIV < 2 || TACH_DIV > 65536 || MS_CYC < 1 || MS_CYC > 2000000 || (TACH_W != 8 && TACH_W != 16))
   begin
      $error("hwmfac_top: unsupported parameter values");
   end

   // Spin-up lengths in cycles; exact, well inside the ten percent allowed.
   localparam logic [31:0] SPIN1 = 32'(`HWMFAC_SPIN1_MS * MS_CYC);
   localparam logic [31:0] SPIN2 = 32'(`HWMFAC_SPIN2_MS * MS_CYC);
   localparam logic [31:0] SPIN3 = 32'(`HWMFAC_SPIN3_MS * MS_CYC);

   function automatic logic [7:0] slope_steps(input logic [2:0] code);
      slope_steps = (code == 3'h0) ? 8'h00 : 8'(8'h01 << (code - 3'h1));
   endfunction

   function automatic logic [31:0] spin_len(input logic [1:0] code);
      case (code)
         2'h1: spin_len = SPIN1;
         2'h2: spin_len = SPIN2;
         2'h3: spin_len = SPIN3;
         default: spin_len = 32'h0;
      endcase
   endfunction

   // ==========================================================
   // Register file
   // ==========================================================
   logic [7:0] cfg_q, sbus_q, ena_q, div_q;
   logic [7:0] start_q [2];
   logic [7:0] ctrl_q [2];
   logic [7:0] fsoff_q [2];
   logic [TACH_W-1:0] lim_q [2];
   logic [TACH_W-1:0] tach_q [2];
   logic [7:0] temp_q, volt_q, rdata_q;
   // A software reset acts on the edge that takes the write, like the pin.
   wire soft_rst = reg_wr && reg_addr == `HWMFAC_OFS_CONFIG && reg_wdata[`HWMFAC_CFG_SWRST];
   wire any_rst = !nrst || soft_rst;

   always_ff @(posedge core_clk)
   begin
      if (any_rst)
      begin
         cfg_q <= `HWMFAC_RST_CONFIG;
         ena_q <= 8'h00;
         div_q <= 8'h00;
         for (int i = 0; i < 2; i++)
         begin
            start_q[i] <= `HWMFAC_RST_START;
            ctrl_q[i] <= `HWMFAC_RST_CTRL;
            fsoff_q[i] <= `HWMFAC_RST_FSOFF;
            lim_q[i] <= '1;
         end
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            `HWMFAC_OFS_CONFIG: cfg_q <= reg_wdata;
            `HWMFAC_OFS_ENABLE: ena_q <= reg_wdata;
            `HWMFAC_OFS_FAN_DIV: div_q <= reg_wdata;
            `HWMFAC_OFS_F4_START: start_q[0] <= {1'b0, reg_wdata[6:0]};
            `HWMFAC_OFS_F5_START: start_q[1] <= {1'b0, reg_wdata[6:0]};
            `HWMFAC_OFS_F4_CTRL: ctrl_q[0] <= {reg_wdata[7], 1'b0, reg_wdata[5:0]};
            `HWMFAC_OFS_F5_CTRL: ctrl_q[1] <= {reg_wdata[7], 1'b0, reg_wdata[5:0]};
            `HWMFAC_OFS_F4_FSOFF: fsoff_q[0] <= reg_wdata;
            `HWMFAC_OFS_F5_FSOFF: fsoff_q[1] <= reg_wdata;
            `HWMFAC_OFS_LIM4_LSB: lim_q[0][7:0] <= reg_wdata;
            `HWMFAC_OFS_LIM5_LSB: lim_q[1][7:0] <= reg_wdata;
            default: ;
         endcase
         if (TACH_W == 16)
         begin
            if (reg_addr == `HWMFAC_OFS_LIM4_MSB)
               lim_q[0][TACH_W-1 -: 8] <= reg_wdata;
            if (reg_addr == `HWMFAC_OFS_LIM5_MSB)
               lim_q[1][TACH_W-1 -: 8] <= reg_wdata;
         end
      end
   end

   // The bus interface address survives a software reset.
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
         sbus_q <= `HWMFAC_RST_SBUS;
      else if (reg_wr && reg_addr == `HWMFAC_OFS_SBUS_ADDR)
         sbus_q <= reg_wdata;
   end

   // ==========================================================
   // Monitoring sequencer
   // ==========================================================
   hwmfac_pkg::hwmfac_mon_type mon_q, mon_d;
   wire loop_ok = cfg_q[`HWMFAC_CFG_START] && !cfg_q[`HWMFAC_CFG_STOP];
   logic [7:0] conv_q;

   always_comb
   begin
      mon_d = mon_q;
      case (mon_q)
         hwmfac_pkg::MON_ONCE: mon_d = (conv_q == 8'hff) ? hwmfac_pkg::MON_IDLE : mon_q;
         hwmfac_pkg::MON_IDLE: mon_d = loop_ok ? hwmfac_pkg::MON_LOOP : mon_q;
         hwmfac_pkg::MON_LOOP: mon_d = loop_ok ? mon_q : hwmfac_pkg::MON_STOP;
         hwmfac_pkg::MON_STOP: mon_d = hwmfac_pkg::MON_IDLE;
         default: mon_d = hwmfac_pkg::MON_IDLE;
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (any_rst)
      begin
         mon_q <= hwmfac_pkg::MON_ONCE;
         conv_q <= 8'h00;
      end
      else
      begin
         mon_q <= mon_d;
         conv_q <= (mon_q == hwmfac_pkg::MON_ONCE) ? conv_q + 8'h01 : 8'h00;
      end
   end

   wire sampling = mon_q == hwmfac_pkg::MON_ONCE || mon_q == hwmfac_pkg::MON_LOOP;

   // Codes pass straight through: 16 mV per step and degrees in two's complement.
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         volt_q <= 8'h00;
         temp_q <= 8'h00;
      end
      else if (sampling)
      begin
         if (ena_q[0] || mon_q == hwmfac_pkg::MON_ONCE)
            volt_q <= volt_code;
         if (ena_q[1] || mon_q == hwmfac_pkg::MON_ONCE)
            temp_q <= temp_sense_input;
      end
   end

   // ==========================================================
   // Tachometer counting
   // ==========================================================
   logic [15:0] pre_q;
   logic [1:0] tin_q;
   logic [TACH_W-1:0] cnt_q [2];
   // The prescaler free-runs, so a period may start mid-tick: one count of error.
   wire tick = pre_q == 16'(TACH_DIV - 1);

   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         pre_q <= 16'h0;
         tin_q <= 2'b00;
         for (int i = 0; i < 2; i++)
         begin
            cnt_q[i] <= '0;
            tach_q[i] <= '1;
         end
      end
      else
      begin
         pre_q <= tick ? 16'h0 : pre_q + 16'h1;
         tin_q <= fan_speed_input;
         for (int i = 0; i < 2; i++)
         begin
            // One rising edge to the next is one input period; two per turn.
            if (fan_speed_input[i] && !tin_q[i])
            begin
               if (sampling && ena_q[2+i])
                  tach_q[i] <= cnt_q[i];
               cnt_q[i] <= '0;
            end
            else if (tick && cnt_q[i] != '1)
               cnt_q[i] <= cnt_q[i] + 1'b1;
         end
      end
   end

   // ==========================================================
   // Automatic drive with spin-up
   // ==========================================================
   logic [31:0] spin_q [2];
   logic [1:0] spin_act_q;
   logic [7:0] smooth_q [2];
   logic [6:0] drv_q [2];

   always_ff @(posedge core_clk)
   begin
      if (any_rst)
      begin
         for (int i = 0; i < 2; i++)
         begin
            spin_q[i] <= 32'h0;
            smooth_q[i] <= 8'h00;
            drv_q[i] <= 7'h00;
         end
         spin_act_q <= 2'b00;
      end
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            logic [7:0] t;
            logic [15:0] duty;
            logic fb_stop;
            logic [8:0] avg;
            t = ctrl_q[i][`HWMFAC_CTL_SMOOTH] ? smooth_q[i] : temp_q;
            duty = 16'(start_q[i][6:0]) + 16'(t[7] ? 8'h00 : t) * 16'(slope_steps(ctrl_q[i][2:0]));
            // Feedback ends spin-up once the reading is no longer above the limit.
            fb_stop = ctrl_q[i][`HWMFAC_CTL_FEEDBK] && tach_q[i] <= lim_q[i];
            // Signed average, so that readings either side of zero do not jump.
            avg = {smooth_q[i][7], smooth_q[i]} + {temp_q[7], temp_q};
            smooth_q[i] <= avg[8:1];
            if (!fan_auto_mode[i] || fan_onoff_mode[i])
            begin
               spin_act_q[i] <= 1'b0;
               spin_q[i] <= 32'h0;
               drv_q[i] <= 7'h00;
            end
            else if (!spin_act_q[i] && drv_q[i] == 7'h00 && spin_len(ctrl_q[i][4:3]) != 32'h0)
            begin
               spin_act_q[i] <= 1'b1;
               spin_q[i] <= spin_len(ctrl_q[i][4:3]);
               drv_q[i] <= `HWMFAC_DUTY_FULL;
            end
            else if (spin_act_q[i])
            begin
               spin_q[i] <= spin_q[i] - 32'h1;
               if (spin_q[i] == 32'h1 || fb_stop)
                  spin_act_q[i] <= 1'b0;
               drv_q[i] <= `HWMFAC_DUTY_FULL;
            end
            else
               drv_q[i] <= (duty > 16'h7f) ? `HWMFAC_DUTY_FULL : duty[6:0];
         end
      end
   end

   // ==========================================================
   // Read path
   // ==========================================================
   logic [7:0] rsel;
   always_comb
   begin
      case (reg_addr)
         `HWMFAC_OFS_CONFIG: rsel = cfg_q;
         `HWMFAC_OFS_SBUS_ADDR: rsel = sbus_q;
         `HWMFAC_OFS_ENABLE: rsel = ena_q;
         `HWMFAC_OFS_FAN_DIV: rsel = div_q;
         `HWMFAC_OFS_VOLT_IN: rsel = volt_q;
         `HWMFAC_OFS_TEMP_IN: rsel = temp_q;
         `HWMFAC_OFS_STATUS: rsel = {4'h0, mon_q};
         `HWMFAC_OFS_TACH4_LSB: rsel = tach_q[0][7:0];
         `HWMFAC_OFS_TACH5_LSB: rsel = tach_q[1][7:0];
         `HWMFAC_OFS_TACH4_MSB: rsel = tach_q[0][TACH_W-1 -: 8] & {8{TACH_W == 16}};
         `HWMFAC_OFS_TACH5_MSB: rsel = tach_q[1][TACH_W-1 -: 8] & {8{TACH_W == 16}};
         `HWMFAC_OFS_LIM4_LSB: rsel = lim_q[0][7:0];
         `HWMFAC_OFS_LIM5_LSB: rsel = lim_q[1][7:0];
         `HWMFAC_OFS_LIM4_MSB: rsel = lim_q[0][TACH_W-1 -: 8] & {8{TACH_W == 16}};
         `HWMFAC_OFS_LIM5_MSB: rsel = lim_q[1][TACH_W-1 -: 8] & {8{TACH_W == 16}};
         `HWMFAC_OFS_F4_START: rsel = start_q[0];
         `HWMFAC_OFS_F5_START: rsel = start_q[1];
         `HWMFAC_OFS_F4_CTRL: rsel = ctrl_q[0];
         `HWMFAC_OFS_F5_CTRL: rsel = ctrl_q[1];
         `HWMFAC_OFS_F4_FSOFF: rsel = fsoff_q[0];
         `HWMFAC_OFS_F5_FSOFF: rsel = fsoff_q[1];
         default: rsel = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (!nrst)
         rdata_q <= 8'h00;
      else
         rdata_q <= reg_rd ? rsel : 8'h00;
   end

   logic run_q, adc_q;
   always_ff @(posedge core_clk)
   begin
      if (any_rst)
      begin
         run_q <= 1'b0;
         adc_q <= 1'b0;
      end
      else
      begin
         run_q <= mon_d == hwmfac_pkg::MON_LOOP;
         adc_q <= mon_d == hwmfac_pkg::MON_LOOP || mon_d == hwmfac_pkg::MON_ONCE;
      end
   end

   assign reg_rdata = rdata_q;
   assign fan4_drive_output = drv_q[0];
   assign fan5_drive_output = drv_q[1];
   assign spinup_active = spin_act_q;
   assign monitor_running = run_q;
   assign adc_active = adc_q;

   // ==========================================================
   // Checks
   // ==========================================================
   chk_start_reserved: assert property (@(posedge core_clk) disable iff (!nrst)
      start_q[0][7] == 1'b0 && start_q[1][7] == 1'b0)
      else $error("start duty reserved bit set");
   chk_spin_full_duty: assert property (@(posedge core_clk) disable iff (!nrst)
      spin_act_q[0] |-> fan4_drive_output == 7'h7f)
      else $error("spin-up without full duty");
   chk_spin5_full_duty: assert property (@(posedge core_clk) disable iff (!nrst)
      spin_act_q[1] |-> fan5_drive_output == `HWMFAC_DUTY_FULL)
      else $error("fan 5 spin-up without full duty");
   chk_fsoff_reset: assert property (@(posedge core_clk)
      !nrst |=> fsoff_q[0] == 8'h7f && fsoff_q[1] == 8'h7f)
      else $error("full speed off limit reset wrong");
   chk_loop_gate: assert property (@(posedge core_clk) disable iff (!nrst)
      monitor_running |-> $past(cfg_q[0]) && !$past(cfg_q[3]))
      else $error("loop running while not enabled");
   chk_swrst_keeps: assert property (@(posedge core_clk) disable iff (!nrst)
      soft_rst |=> $stable(sbus_q) && cfg_q == 8'h00)
      else $error("software reset wrong");
   chk_once_idle: assert property (@(posedge core_clk) disable iff (!nrst)
      $rose(nrst) |-> ##[1:300] mon_q != hwmfac_pkg::MON_ONCE)
      else $error("power-up measurement never ended");
   chk_tach_saturate: assert property (@(posedge core_clk) disable iff (!nrst)
      cnt_q[0] == '1 && !(fan_speed_input[0] && !tin_q[0]) |=> cnt_q[0] == '1)
      else $error("tach counter wrapped");
   chk_rd_data: assert property (@(posedge core_clk) disable iff (!nrst)
      reg_rd && reg_addr == `HWMFAC_OFS_F4_CTRL && !reg_wr |=> reg_rdata == $past(ctrl_q[0]))
      else $error("control readback wrong");
   chk_no_spin_zero: assert property (@(posedge core_clk) disable iff (!nrst)
      $rose(spin_act_q[0]) |-> $past(ctrl_q[0][4:3]) != 2'b00)
      else $error("spin-up with zero time");
endmodule
`default_nettype wire

// >>> test/hwmfac_sense_model.sv
/*
 Sensing-side model: two fan tach lines, a thermistor code and a voltage code.
 Assumes the bench sets the tach half periods and the codes.
*/
`default_nettype none
module hwmfac_sense_model (
   // Clock.
   input wire logic core_clk,
   // Bench settings.
   input wire logic [1:0][15:0] half,
   input wire logic [7:0] temp_deg,
   input wire logic [7:0] volt_lsb,
   // Sensed values.
   output logic [1:0] fan_speed_input,
   output logic [7:0] temp_sense_input,
   output logic [7:0] volt_code
);
   timeunit 1ns;
   timeprecision 1ps;
   // =========================================
   // Tach lines
   logic [1:0][15:0] cnt_q = '0;
   logic [1:0] tach_q = 2'b00;
   // A fan gives two tach periods per revolution; it is not reset with the chip.
   always_ff @(posedge core_clk)
   begin
      for (int i = 0; i < 2; i++)
      begin
         cnt_q[i] <= (cnt_q[i] + 16'h0001 >= half[i]) ? 16'h0000 : cnt_q[i] + 16'h0001;
         if (cnt_q[i] + 16'h0001 >= half[i]) tach_q[i] <= ~tach_q[i];
      end
   end
   assign fan_speed_input = tach_q;
   // =========================================
   // Converted codes
   assign temp_sense_input = temp_deg;
   assign volt_code = volt_lsb;
endmodule
`default_nettype wire

// >>> test/tb.sv
/*
 Self-checking bench for the fan automatic-control block.
 Assumes shortened spin and tach counts set through the top's parameters.
*/
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int MS = 10;
   localparam logic [7:0] ofs [6] = '{8'h93, 8'h94, 8'h95, 8'h9b, 8'h9c, 8'h9d};
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [1:0] fan_auto_mode = 2'b00;
   logic [1:0] fan_onoff_mode = 2'b11;
   logic [1:0][15:0] half = {16'h0320, 16'h0028};
   logic [7:0] temp_deg = 8'h00;
   logic [7:0] volt_lsb = 8'h00;
   logic [7:0] reg_rdata, temp_sense_input, volt_code, adr, v;
   logic [6:0] d4, d5, sd;
   logic [1:0] fan_speed_input, spinup_active;
   logic monitor_running, adc_active;
   int mismatches = 0;
   int compares = 0;
   int cyc = 0;
   int n, bad;
   hwmfac_top #(.TACH_DIV(4), .MS_CYC(MS), .TACH_W(8)) uut (.core_clk(core_clk), .nrst(nrst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .fan_speed_input(fan_speed_input), .temp_sense_input(temp_sense_input), .volt_code(volt_code),
      .fan_auto_mode(fan_auto_mode), .fan_onoff_mode(fan_onoff_mode), .fan4_drive_output(d4),
      .fan5_drive_output(d5), .spinup_active(spinup_active), .monitor_running(monitor_running),
      .adc_active(adc_active));
   hwmfac_sense_model model (.core_clk(core_clk), .half(half), .temp_deg(temp_deg), .volt_lsb(volt_lsb),
      .fan_speed_input(fan_speed_input), .temp_sense_input(temp_sense_input), .volt_code(volt_code));
   always #2 core_clk = ~core_clk;
   // =========================================
   // Checks, bus tasks and expectations
   task automatic results();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 60000)
      begin
         mismatches++;
         results();
      end
   end
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(posedge core_clk);
      d = reg_rdata;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      chk($sformatf("reg %h", a), {8'h00, exp}, {8'h00, d});
   endtask
   // Reserved bits of start duty and control read back as zero.
   function automatic logic [7:0] rb(input logic [7:0] a, input logic [7:0] d);
      if (a == 8'h93 || a == 8'h9b) return d & 8'h7f;
      if (a == 8'h94 || a == 8'h9c) return d & 8'hbf;
      return d;
   endfunction
   function automatic int spin_cyc(input logic [1:0] c);
      return (c == 2'b01) ? 125 * MS : (c == 2'b10) ? 325 * MS : (c == 2'b11) ? 1000 * MS : 0;
   endfunction
   function automatic logic [15:0] near(input int got, input int exp);
      return 16'((got >= exp - 2 && got <= exp + 2) ? exp : got);
   endfunction
   // On/off mode drops the drive to zero, so leaving it starts a fresh spin-up when the control's spin-up time code is not zero.
   task automatic spin(input logic [7:0] ctrl);
      wr(8'h94, ctrl);
      @(posedge core_clk);
      fan_onoff_mode <= 2'b01;
      repeat (4) @(posedge core_clk);
      chk("spin in onoff", 16'h0000, {15'h0000, spinup_active[0]});
      fan_onoff_mode <= 2'b00;
      n = 0;
      bad = 0;
      for (int i = 0; i < 12000; i++)
      begin
         @(posedge core_clk);
         #1;
         if (spinup_active[0] === 1'b1)
         begin
            n++;
            if (d4 !== 7'h7f) bad++;
         end
         else if (n > 0 || i > 20) break;
      end
      chk("spin duty", 16'h0000, 16'(bad));
   endtask
   // =========================================
   // Main sequence
   initial
   begin
      void'($urandom(32'hf9569b82));
      repeat (8) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      #1 chk("adc after reset", 16'h0001, {15'h0000, adc_active});
      for (int i = 0; i < 6; i++) rchk(ofs[i], (i % 3 == 2) ? 8'h7f : 8'h00);
      rchk(8'h48, 8'h2d);
      rchk(8'h7e, 8'h00);
      repeat (300) @(posedge core_clk);
      #1 chk("adc idle", 16'h0000, {15'h0000, adc_active});
      for (int i = 0; i < 12; i++)
      begin
         adr = ofs[$urandom_range(5)];
         v = 8'($urandom);
         wr(adr, v);
         rchk(adr, rb(adr, v));
      end
      volt_lsb <= 8'($urandom);
      wr(8'h84, 8'h00);
      wr(8'h85, 8'h00);
      wr(8'h50, 8'h0f);
      wr(8'h00, 8'h01);
      repeat (2) @(posedge core_clk);
      #1 chk("running", 16'h0001, {15'h0000, monitor_running});
      wr(8'h00, 8'h09);
      repeat (2) @(posedge core_clk);
      #1 chk("stopped", 16'h0000, {15'h0000, monitor_running});
      wr(8'h00, 8'h01);
      repeat (4000) @(posedge core_clk);
      rd(8'h80, v);
      chk("tach4", 16'h0014, (v == 8'h13 || v == 8'h15) ? 16'h0014 : {8'h00, v});
      rchk(8'h81, 8'h00);
      rchk(8'h82, 8'hff);
      rchk(8'h20, volt_lsb);
      foreach (ofs[i])
      begin
         if (i > 2) break;
         temp_deg <= (i == 0) ? 8'h7d : (i == 1) ? 8'hff : 8'hc9;
         repeat (600) @(posedge core_clk);
         rchk(8'h29, temp_deg);
      end
      wr(8'h50, 8'h00);
      v = volt_lsb;
      volt_lsb <= ~volt_lsb;
      repeat (600) @(posedge core_clk);
      rchk(8'h20, v);
      wr(8'h50, 8'h0f);
      sd = 7'($urandom) | 7'h01;
      wr(8'h93, {1'b0, sd});
      fan_auto_mode <= 2'b01;
      for (int c = 0; c < 4; c++)
      begin
         v = 8'($urandom);
         spin({v[7], 2'b00, 2'(c), v[2:0]});
         chk("spin length", 16'(spin_cyc(2'(c))), near(n, spin_cyc(2'(c))));
         repeat (4) @(posedge core_clk);
         #1 chk("start duty", {9'h000, sd}, {9'h000, d4});
      end
      spin(8'h28);
      chk("low limit spin", 16'(spin_cyc(2'b01)), near(n, spin_cyc(2'b01)));
      wr(8'h84, 8'hff);
      wr(8'h85, 8'hff);
      spin(8'h38);
      chk("feedback spin", 16'h0001, {15'h0000, n > 0 && n < 200});
      wr(8'h94, 8'h02);
      temp_deg <= 8'h03;
      repeat (600) @(posedge core_clk);
      chk("slope duty", 16'((sd > 7'h79) ? 7'h7f : sd + 7'h06), {9'h000, d4});
      chk("fan5 idle", 16'h0000, {7'h00, spinup_active[1], 1'b0, d5});
      wr(8'h48, 8'h5a);
      wr(8'h95, 8'h33);
      wr(8'h00, 8'h80);
      repeat (2) @(posedge core_clk);
      rchk(8'h95, 8'h7f);
      rchk(8'h48, 8'h5a);
      rchk(8'h00, 8'h00);
      chk("running after swreset", 16'h0000, {15'h0000, monitor_running});
      results();
   end
endmodule
`default_nettype wire
